// [hw/hbc_device.sv]
// Counter end: transfer byte counter, sticky event flags and interrupt pin.
// Assumes event inputs are one-cycle pulses from logic on core_clk, and that
// the end-of-transfer pin is asynchronous and must be synchronised here.
//
// Strobed register access was chosen for this implementation.
`default_nettype none

// What this block does
// - Sixteen-bit byte count register, resets to zero.
// - Count acts only while counter gate set.
// - Count reached: end event, done flag, fill update.
// - Codes 22h/A2h count, 24h/A4h flags.
// - Flags live from reset; upper six reserved zero.
// - Interrupt needs flag, mask bit, global enable.
// - Flags clear only by writing ones.
// - Software writes ones to clear everything; a flag set in the clearing cycle stays set.
// - Bit 9 sets on dual-role event.
// - Bit 8 sets on async count/time limit.
// - Bit 7 sets on acknowledged periodic list end.
// - Bit 6 sets when clock returns after suspend.
// - Bit 5 sets on entering suspend.
// - No frame start needed while suspended.
// - Bit 4 sets on operational event.
// - Bit 3 sets at zero count or pin.
// - Bit 2 sets on second iso buffer done.
// - Bit 1 sets on first iso buffer done.
// - Bit 0 sets on new frame start.
// - Mask bits zero after power-on.
module hbc_device
  import hbc_pkg::*;
(
  // Clock and synchronous reset.
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  // Register port toward the processor end.
  hbc_if.device                      link,
  // Configuration levels from the setup and mask registers.
  input  wire logic                  byte_count_gate,
  input  wire logic                  global_irq_enable,
  input  wire logic [HBC_FLAG_W-1:0] host_cpu_event_mask,
  // Byte strobe from the list buffer data path.
  input  wire logic                  byte_moved,
  // Event pulses from the other units.
  input  wire logic                  sof_event,
  input  wire logic                  iso_a_done,
  input  wire logic                  iso_b_done,
  input  wire logic                  operational_event,
  input  wire logic                  asleep_enter,
  input  wire logic                  clock_back,
  input  wire logic                  periodic_last_acked,
  input  wire logic                  async_count_hit,
  input  wire logic                  async_time_hit,
  input  wire logic                  dual_role_event,
  // Asynchronous end-of-transfer pin, active high.
  input  wire logic                  end_of_transfer,
  // Results toward the other units.
  output logic                       transfer_done_evt,
  output logic                       buffer_fill_update,
  output logic                       hc_asleep,
  output logic                       sof_permitted
);

  // All state of the counter end in one word.
  typedef struct packed {
    logic [HBC_DATA_W-1:0] byte_total;   // Remaining byte count.
    logic [HBC_FLAG_W-1:0] flags;        // Sticky event flags.
    logic                  irq;          // Registered interrupt pin.
    logic [HBC_DATA_W-1:0] rdata;        // Registered read answer.
    logic                  rvalid;       // Read answer marker.
    logic [1:0]            eot_sync;     // Pin synchroniser pair.
    logic                  eot_prev;     // Last synchronised pin level.
    logic                  asleep;       // Suspended state of the controller.
    logic                  done_evt;     // End-of-transfer pulse.
    logic                  fill_upd;     // Buffer fill-state update pulse.
    logic                  sof_ok;       // Registered frame start permission.
  } hbc_dev_s;

  hbc_dev_s state;       // Registered state.
  hbc_dev_s next_state;  // Next state built combinationally.

  // Decoded command strobes.
  logic                  wr_count;   // Write to the byte count.
  logic                  wr_flags;   // Write-one-to-clear to the flags.
  logic                  rd_count;   // Read of the byte count.
  logic                  rd_flags;   // Read of the flags.
  logic                  count_end;  // Last byte counted this cycle.
  logic                  pin_rise;   // Synchronised pin rising edge.
  logic                  any_done;   // Either completion cause.
  logic [HBC_FLAG_W-1:0] set_vec;    // Flags raised this cycle.
  logic [HBC_FLAG_W-1:0] clr_vec;    // Flags cleared this cycle.

  // Command decode; unknown codes are ignored and reads of them answer zero.
  always_comb begin
    wr_count = link.cmd_valid && (link.cmd_code == HBC_WR_COUNT);
    wr_flags = link.cmd_valid && (link.cmd_code == HBC_WR_FLAGS);
    rd_count = link.cmd_valid && (link.cmd_code == HBC_RD_COUNT);
    rd_flags = link.cmd_valid && (link.cmd_code == HBC_RD_FLAGS);
  end

  // Completion causes. A count of zero under the gate never fires, so a gate
  // raised before software loads the count does not end a transfer early.
  always_comb begin
    // A load in the same cycle replaces the count, so that byte ends nothing.
    count_end = byte_count_gate && byte_moved && !wr_count &&
                (state.byte_total == 16'h0001);
    // Only the second flip-flop of the synchroniser is read here.
    pin_rise  = state.eot_sync[1] && !state.eot_prev;
    any_done  = count_end || pin_rise;
  end

  // Per-flag set sources, one to a bit except bits 3 and 8, which each merge two causes.
  always_comb begin
    set_vec                  = '0;
    set_vec[HBC_B_SOF]       = sof_event;
    set_vec[HBC_B_ISO_A]     = iso_a_done;
    set_vec[HBC_B_ISO_B]     = iso_b_done;
    set_vec[HBC_B_DONE]      = any_done;
    set_vec[HBC_B_OPER]      = operational_event;
    set_vec[HBC_B_ASLEEP]    = asleep_enter;
    set_vec[HBC_B_CLK_BACK]  = clock_back;
    set_vec[HBC_B_PERIODIC]  = periodic_last_acked;
    set_vec[HBC_B_ASYNC]     = async_count_hit || async_time_hit;
    set_vec[HBC_B_DUAL_ROLE] = dual_role_event;
    // Only ones in the write data clear; zeros leave a flag alone.
    clr_vec = wr_flags ? link.cmd_wdata[HBC_FLAG_W-1:0] : '0;
  end

  // Next-state logic for the whole counter end.
  always_comb begin
    next_state = state;

    // The pin passes two flip-flops before any logic looks at it.
    next_state.eot_sync = {state.eot_sync[0], end_of_transfer};
    next_state.eot_prev = state.eot_sync[1];

    // Byte counter: a software load wins over a byte in the same cycle.
    if (wr_count) begin
      next_state.byte_total = link.cmd_wdata;
    end else if (byte_count_gate && byte_moved &&
                 (state.byte_total != '0)) begin
      next_state.byte_total = state.byte_total - 16'h0001;
    end

    // Sticky flags: a set in the clearing cycle survives the clear.
    next_state.flags = (state.flags & ~clr_vec) | set_vec;

    // Interrupt level: set flag, enabled by mask, under the global enable.
    // The mask itself lives outside and powers up as all zeros.
    next_state.irq = global_irq_enable &&
                     (|(next_state.flags & host_cpu_event_mask));

    // Read answer stands for exactly the cycle after the read command.
    next_state.rvalid = rd_count || rd_flags;
    if (rd_count) begin
      next_state.rdata = state.byte_total;
    end else if (rd_flags) begin
      // Reserved upper bits always read as zero.
      next_state.rdata = {{(HBC_DATA_W-HBC_FLAG_W){1'b0}}, state.flags};
    end else begin
      next_state.rdata = '0;
    end

    // Suspend tracking: entry sets it, the clock returning clears it.
    if (asleep_enter) begin
      next_state.asleep = 1'b1;
    end else if (clock_back) begin
      next_state.asleep = 1'b0;
    end

    // Frame permission is registered so the output comes straight from a flop.
    next_state.sof_ok = !next_state.asleep;

    // End-of-transfer pulse and fill-state update to the buffer logic.
    next_state.done_evt = any_done;
    next_state.fill_upd = any_done;

    // Synchronous reset brings every field to a constant.
    if (rst) begin
      next_state.byte_total = HBC_COUNT_RST;
      next_state.flags      = HBC_FLAGS_RST;
      next_state.irq        = 1'b0;
      next_state.rdata      = '0;
      next_state.rvalid     = 1'b0;
      next_state.eot_sync   = 2'b00;
      next_state.eot_prev   = 1'b0;
      next_state.asleep     = 1'b0;
      next_state.done_evt   = 1'b0;
      next_state.fill_upd   = 1'b0;
      next_state.sof_ok     = 1'b1;
    end
  end

  // Single register stage for the whole state.
  always_ff @(posedge core_clk) begin
    state <= next_state;
  end

  // Outputs come straight from the state flip-flops.
  assign link.rsp_rdata    = state.rdata;
  assign link.rsp_valid    = state.rvalid;
  assign link.host_irq_pin = state.irq;
  assign transfer_done_evt  = state.done_evt;
  assign buffer_fill_update = state.fill_upd;
  assign hc_asleep          = state.asleep;
  // Frame starts may be skipped while the controller sleeps; the permission
  // follows the suspend state with the same one-cycle timing.
  assign sof_permitted      = state.sof_ok;

endmodule : hbc_device

`default_nettype wire

// [hw/hbc_pkg.sv]
// Shared constants for the host byte counter and processor event flag block.
// Assumes both ends and the joining interface import this package whole.
`default_nettype none

package hbc_pkg;

  // Width of the register port data path and of the byte counter.
  localparam int unsigned HBC_DATA_W  = 16;
  // Number of live event flags; bits above them are reserved.
  localparam int unsigned HBC_FLAG_W  = 10;
  // Width of a command code on the register port.
  localparam int unsigned HBC_CODE_W  = 8;

  // Command codes: reads have bit 7 clear, writes have bit 7 set.
  localparam logic [7:0] HBC_RD_COUNT = 8'h22;
  localparam logic [7:0] HBC_WR_COUNT = 8'ha2;
  localparam logic [7:0] HBC_RD_FLAGS = 8'h24;
  localparam logic [7:0] HBC_WR_FLAGS = 8'ha4;

  // Reset values of the two registers.
  localparam logic [15:0] HBC_COUNT_RST = 16'h0000;
  localparam logic [9:0]  HBC_FLAGS_RST = 10'h000;

  // Bit positions inside the event flag register.
  localparam int unsigned HBC_B_SOF       = 0;
  localparam int unsigned HBC_B_ISO_A     = 1;
  localparam int unsigned HBC_B_ISO_B     = 2;
  localparam int unsigned HBC_B_DONE      = 3;
  localparam int unsigned HBC_B_OPER      = 4;
  localparam int unsigned HBC_B_ASLEEP    = 5;
  localparam int unsigned HBC_B_CLK_BACK  = 6;
  localparam int unsigned HBC_B_PERIODIC  = 7;
  localparam int unsigned HBC_B_ASYNC     = 8;
  localparam int unsigned HBC_B_DUAL_ROLE = 9;

  // Software-side address map of the host end (word addresses).
  localparam logic [1:0] HBC_A_COUNT  = 2'h0;
  localparam logic [1:0] HBC_A_FLAGS  = 2'h1;
  localparam logic [1:0] HBC_A_STATUS = 2'h2;

endpackage : hbc_pkg

`default_nettype wire

// [hw/hbc_if.sv]
// Command-coded register port joining the processor end and the counter end.
// Assumes one shared clock; the device answers a read on the following cycle.
`default_nettype none

interface hbc_if;
  import hbc_pkg::*;

  logic                  cmd_valid;   // One-cycle command strobe.
  logic [HBC_CODE_W-1:0] cmd_code;    // Command code, bit 7 marks a write.
  logic [HBC_DATA_W-1:0] cmd_wdata;   // Write data beside a write code.
  logic [HBC_DATA_W-1:0] rsp_rdata;   // Read data, one cycle after the read.
  logic                  rsp_valid;   // Marks rsp_rdata valid.
  logic                  host_irq_pin; // Active-high interrupt request level.

  // The counter end answers commands and drives the interrupt pin.
  modport device (
    input  cmd_valid, cmd_code, cmd_wdata,
    output rsp_rdata, rsp_valid, host_irq_pin
  );

  // The processor end issues commands and watches the interrupt pin.
  modport host (
    output cmd_valid, cmd_code, cmd_wdata,
    input  rsp_rdata, rsp_valid, host_irq_pin
  );

endinterface : hbc_if

`default_nettype wire

// [hw/hbc_host.sv]
// Processor end: turns software register accesses into command codes.
// Assumes software strobes come from logic on core_clk, never both at once.
`default_nettype none

module hbc_host
  import hbc_pkg::*;
(
  // Clock and synchronous reset.
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  // Software register port.
  input  wire logic [1:0]            sw_addr,
  input  wire logic [HBC_DATA_W-1:0] sw_wdata,
  input  wire logic                  sw_wr,
  input  wire logic                  sw_rd,
  output logic      [HBC_DATA_W-1:0] sw_rdata,
  // Register port toward the counter end.
  hbc_if.host                        link
);

  // All state of the processor end in one word.
  typedef struct packed {
    logic                  local_rd;  // Last read was of the status word.
    logic                  irq_seen;  // Interrupt pin seen at the last edge.
  } hbc_host_s;

  hbc_host_s state;       // Registered state.
  hbc_host_s next_state;  // Next state.

  // Commands pass through in the strobe cycle so the device answer lands in
  // the cycle after the read, as software expects; the cost is that these
  // outputs follow the caller's flip-flops rather than our own.
  always_comb begin
    link.cmd_valid = 1'b0;
    link.cmd_code  = '0;
    link.cmd_wdata = sw_wdata;
    if ((sw_wr || sw_rd) && (sw_addr == HBC_A_COUNT)) begin
      link.cmd_valid = 1'b1;
      link.cmd_code  = sw_wr ? HBC_WR_COUNT : HBC_RD_COUNT;
    end else if ((sw_wr || sw_rd) && (sw_addr == HBC_A_FLAGS)) begin
      // Ones in the data clear; all ones clears every flag not set again in the same cycle.
      link.cmd_valid = 1'b1;
      link.cmd_code  = sw_wr ? HBC_WR_FLAGS : HBC_RD_FLAGS;
    end
  end

  // Local status read and interrupt sampling.
  always_comb begin
    next_state.local_rd = sw_rd && (sw_addr == HBC_A_STATUS);
    next_state.irq_seen = link.host_irq_pin;
    if (rst) begin
      next_state = '0;
    end
  end

  // Single register stage.
  always_ff @(posedge core_clk) begin
    state <= next_state;
  end

  // Read data: the device answer, or the local status word, else zero.
  assign sw_rdata = state.local_rd ? {{(HBC_DATA_W-1){1'b0}}, state.irq_seen} :
                    (link.rsp_valid ? link.rsp_rdata : '0);

endmodule : hbc_host

`default_nettype wire

// [tb/hbc_checker.sv]
// Checker for the command port between the processor end and the counter end.
// Assumes it is placed beside the interface instance and sees every command.
`default_nettype none

module hbc_checker
  import hbc_pkg::*;
(
  // Clock and reset.
  input wire logic                  core_clk,
  input wire logic                  rst,
  // Command and answer signals of the port.
  input wire logic                  cmd_valid,
  input wire logic [HBC_CODE_W-1:0] cmd_code,
  input wire logic [HBC_DATA_W-1:0] cmd_wdata,
  input wire logic [HBC_DATA_W-1:0] rsp_rdata,
  input wire logic                  rsp_valid,
  input wire logic                  host_irq_pin
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  logic                  rd_cmd;     // A read that must be answered.
  logic                  was_rd_flg; // The last command read the flags.
  logic [HBC_FLAG_W-1:0] low_flags;  // Flags known to be set.
  assign rd_cmd = cmd_valid && (cmd_code == HBC_RD_COUNT || cmd_code == HBC_RD_FLAGS);

  // Keep a lower bound of set flags; it only shrinks on a clear write.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      low_flags  <= '0;
      was_rd_flg <= 1'b0;
    end else begin
      was_rd_flg <= cmd_valid && cmd_code == HBC_RD_FLAGS;
      if (cmd_valid && cmd_code == HBC_WR_FLAGS) begin
        low_flags <= low_flags & ~cmd_wdata[HBC_FLAG_W-1:0];
      end else if (rsp_valid && was_rd_flg) begin
        low_flags <= rsp_rdata[HBC_FLAG_W-1:0];
      end
    end
  end

  AST_RD_ANSWER: assert property (rd_cmd |=> rsp_valid)
    else $error("read command not answered");
  AST_WR_SILENT: assert property (cmd_valid && cmd_code[7] |=> !rsp_valid)
    else $error("write command answered");
  AST_RSP_CAUSE: assert property (rsp_valid |-> $past(rd_cmd))
    else $error("answer without a read");
  AST_IDLE_ZERO: assert property (!rsp_valid |-> rsp_rdata == '0)
    else $error("read data not zero while idle");
  AST_RESERVED_ZERO: assert property (
    rsp_valid && was_rd_flg |-> rsp_rdata[15:10] == 6'h00)
    else $error("reserved flag bits not zero");
  AST_FLAGS_KEEP: assert property (rsp_valid && was_rd_flg |->
    (rsp_rdata[HBC_FLAG_W-1:0] & low_flags) == low_flags)
    else $error("flag cleared without a clear write");
  AST_COUNT_LOAD: assert property (cmd_valid && cmd_code == HBC_WR_COUNT ##1
    cmd_valid && cmd_code == HBC_RD_COUNT |=> rsp_rdata == $past(cmd_wdata, 2))
    else $error("count read back differs from write");
  AST_RESET_QUIET: assert property ($fell(rst) |-> !host_irq_pin && !rsp_valid)
    else $error("pin or answer active after reset");
endmodule : hbc_checker

`default_nettype wire

// [tb/tb_top.sv]
// Bench joining both ends through the port, with random and corner stimulus.
// Assumes the checker watches the port; expectations come from a flag model.
`default_nettype none

module tb_top
  import hbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        core_clk, rst, sw_wr, sw_rd, gate, gie, bm, at, done_evt, fill, asleep, sof_ok;
  logic [1:0]  sw_addr, dn;     // Software address and captured done pulses.
  logic [15:0] sw_wdata, sw_rdata, v;
  logic [9:0]  ev, mask, expf;  // Event pulses, mask and expected flags.
  int          n_errors, cmp_count, i, k;

  hbc_if link_bus ();
  hbc_host hbc_host_inst (.core_clk(core_clk), .rst(rst), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .link(link_bus));
  // Event bit i drives the source of flag i; bit 3 drives the transfer pin.
  hbc_device hbc_device_inst (.core_clk(core_clk), .rst(rst), .link(link_bus),
    .byte_count_gate(gate), .global_irq_enable(gie), .host_cpu_event_mask(mask),
    .byte_moved(bm), .sof_event(ev[0]), .iso_a_done(ev[1]), .iso_b_done(ev[2]),
    .end_of_transfer(ev[3]), .operational_event(ev[4]), .asleep_enter(ev[5]),
    .clock_back(ev[6]), .periodic_last_acked(ev[7]), .async_count_hit(ev[8]),
    .async_time_hit(at), .dual_role_event(ev[9]), .transfer_done_evt(done_evt),
    .buffer_fill_update(fill), .hc_asleep(asleep), .sof_permitted(sof_ok));
  hbc_checker hbc_checker_inst (.core_clk(core_clk), .rst(rst),
    .cmd_valid(link_bus.cmd_valid), .cmd_code(link_bus.cmd_code),
    .cmd_wdata(link_bus.cmd_wdata), .rsp_rdata(link_bus.rsp_rdata),
    .rsp_valid(link_bus.rsp_valid), .host_irq_pin(link_bus.host_irq_pin));

  // Free-running core clock.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Compare one value and count it.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Flag model: ones in the clear word drop flags, and a set wins over a clear.
  function automatic logic [9:0] flag_model(input logic [9:0] cur, input logic [9:0] src,
                                            input logic [9:0] clr);
    return (cur & ~clr) | src;
  endfunction : flag_model

  // One-cycle write; a caller never issues two writes back to back.
  task automatic wr(input logic [1:0] a, input logic [15:0] w);
    sw_addr  <= a;
    sw_wdata <= w;
    sw_wr    <= 1'b1;
    @(posedge core_clk);
    sw_wr <= 1'b0;
  endtask : wr

  // One-cycle read; data stand only in the cycle after the strobe.
  task automatic rdchk(input logic [1:0] a, input logic [15:0] e);
    sw_addr <= a;
    sw_rd   <= 1'b1;
    @(posedge core_clk);
    sw_rd <= 1'b0;
    #1 chk(sw_rdata, e);
    @(posedge core_clk);
  endtask : rdchk

  // Pulse sources, then wait out the pin synchroniser before looking.
  task automatic pulse(input logic [9:0] m);
    ev <= m;
    @(posedge core_clk);
    ev <= '0;
    repeat (4) @(posedge core_clk);
    expf = flag_model(expf, m, 10'h000);
  endtask : pulse

  // Look at the registered interrupt pin one edge after an input change.
  task automatic irq_is(input logic e);
    @(posedge core_clk);
    #1 chk({15'h0, link_bus.host_irq_pin}, {15'h0, e});
    @(posedge core_clk);
  endtask : irq_is

  // One byte strobe; the done pulses are caught in the following cycle.
  task automatic mv;
    bm <= 1'b1;
    @(posedge core_clk);
    bm <= 1'b0;
    #1 dn = {done_evt, fill};
    @(posedge core_clk);
  endtask : mv

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish

  // Watchdog sized well above the few hundred cycles the tests need.
  initial begin
    #200000;
    n_errors++;
    tally_and_finish();
  end

  // Main sequence of tests.
  initial begin
    {rst, sw_wr, sw_rd, gate, gie, bm, at} = 7'h40;
    {sw_addr, sw_wdata, ev, mask, expf} = '0;
    n_errors = 0;
    cmp_count = 0;
    void'($urandom(98));
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rdchk(HBC_A_COUNT, 16'h0000);
    rdchk(HBC_A_FLAGS, 16'h0000);
    rdchk(2'h3, 16'h0000);
    chk({14'h0, asleep, sof_ok}, 16'h0001);
    $display("test reset done");
    // Count load and read back, corners first; the read follows at once.
    for (i = 0; i < 6; i++) begin
      v = (i == 0) ? 16'hffff : (i == 1) ? 16'h0001 : 16'($urandom);
      wr(HBC_A_COUNT, v);
      rdchk(HBC_A_COUNT, v);
    end
    $display("test count done");
    // Every flag from one source each, masked off so the pin must stay low.
    gie <= 1'b1;
    for (i = 0; i < 10; i++) begin
      pulse(10'h1 << i);
      rdchk(HBC_A_FLAGS, {6'h0, expf});
      if (i == 5) chk({14'h0, asleep, sof_ok}, 16'h0002);
    end
    chk({14'h0, asleep, sof_ok}, 16'h0001);
    irq_is(1'b0);
    wr(HBC_A_FLAGS, 16'h0000);
    rdchk(HBC_A_FLAGS, {6'h0, expf});
    wr(HBC_A_FLAGS, 16'h00ff);
    expf = 10'h300;
    rdchk(HBC_A_FLAGS, {6'h0, expf});
    wr(HBC_A_FLAGS, 16'h03ff);
    at <= 1'b1;
    @(posedge core_clk);
    at <= 1'b0;
    expf = 10'h100;
    rdchk(HBC_A_FLAGS, {6'h0, expf});
    for (i = 0; i < 6; i++) begin
      pulse(10'($urandom));
      rdchk(HBC_A_FLAGS, {6'h0, expf});
      v = 16'($urandom);
      wr(HBC_A_FLAGS, v);
      expf = flag_model(expf, 10'h000, v[9:0]);
      rdchk(HBC_A_FLAGS, {6'h0, expf});
    end
    wr(HBC_A_FLAGS, 16'h03ff);
    expf = '0;
    $display("test flags done");
    // Pin needs flag, its mask bit and the global enable together.
    k = $urandom_range(9, 0);
    mask <= 10'h1 << k;
    irq_is(1'b0);
    pulse(10'h1 << k);
    irq_is(1'b1);
    rdchk(HBC_A_STATUS, 16'h0001);
    mask <= ~(10'h1 << k);
    irq_is(1'b0);
    mask <= 10'h1 << k;
    gie <= 1'b0;
    irq_is(1'b0);
    gie <= 1'b1;
    irq_is(1'b1);
    // A source pulse in the very cycle of its clear keeps the flag.
    ev <= expf;
    wr(HBC_A_FLAGS, {6'h0, expf});
    ev <= '0;
    repeat (4) @(posedge core_clk);
    rdchk(HBC_A_FLAGS, {6'h0, expf});
    wr(HBC_A_FLAGS, {6'h0, expf});
    expf = '0;
    #1 chk({15'h0, link_bus.host_irq_pin}, 16'h0000);
    @(posedge core_clk);
    $display("test pin done");
    // Bytes are ignored without the gate, then count down and stop at zero.
    wr(HBC_A_COUNT, 16'h0003);
    mv();
    rdchk(HBC_A_COUNT, 16'h0003);
    gate <= 1'b1;
    for (i = 2; i >= 0; i--) begin
      mv();
      chk({14'h0, dn}, (i == 0) ? 16'h0003 : 16'h0000);
      rdchk(HBC_A_COUNT, 16'(i));
    end
    rdchk(HBC_A_FLAGS, 16'h0008);
    mv();
    chk({14'h0, dn}, 16'h0000);
    rdchk(HBC_A_COUNT, 16'h0000);
    $display("test counter done");
    tally_and_finish();
  end
endmodule : tb_top

`default_nettype wire
